// [include/bss_defs.svh]
// Constants of the brake and stop sequencer.
`ifndef BSS_DEFS_SVH
`define BSS_DEFS_SVH

`define BSS_ADDR_CONTROL 8'h00
`define BSS_ADDR_DELAY 8'h04
`define BSS_ADDR_ROT_LEVEL 8'h08
`define BSS_ADDR_LIN_LEVEL 8'h0C
`define BSS_ADDR_WAIT 8'h10
`define BSS_ADDR_MAX_SPEED 8'h14
`define BSS_ADDR_STATUS 8'h18

`define BSS_CTL_LINEAR 0
`define BSS_CTL_ZS_EN 1
`define BSS_CTL_DECEL 2
`define BSS_CTL_METHOD_LO 4
`define BSS_CTL_METHOD_HI 5

`define BSS_RST_LINEAR 1'b0
`define BSS_RST_ZS_EN 1'b1
`define BSS_RST_DECEL 1'b0
`define BSS_RST_METHOD 2'h0
`define BSS_RST_DELAY 7'h00
`define BSS_RST_ROT_LEVEL 14'h0064
`define BSS_RST_LIN_LEVEL 14'h000A
`define BSS_RST_WAIT 7'h32
`define BSS_RST_MAX_SPEED 14'h2710
`define BSS_RST_SYNC 4'h1

`define BSS_DELAY_MIN 14'h0000
`define BSS_DELAY_MAX 14'h0032
`define BSS_WAIT_MIN 14'h000A
`define BSS_WAIT_MAX 14'h0064
`define BSS_LEVEL_MIN 14'h0000
`define BSS_LEVEL_MAX 14'h2710
`define BSS_METHOD_MAX 2'h2

`define BSS_TICK_MS 10
`define BSS_CLK_KHZ 25000

`endif

// [include/bss_pkg.sv]
// Types shared by the brake and stop sequencer files.
package bss_pkg;

    typedef logic [13:0] bss_speed_t;
    typedef logic [6:0] bss_units_t;

    typedef enum logic [2:0] {
        S_RUN,
        S_ZSTOP,
        S_DELAY,
        S_RSTOP,
        S_STOPPED
    } bss_state_t;

    typedef struct packed {
        logic powerOn;
        logic dynBrake;
        logic coast;
        logic zeroClamp;
        logic decel;
    } bss_drive_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } bss_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } bss_apb_rsp_t;

endpackage : bss_pkg

// [hw/bss_unit_timer.sv]
// Down-counter of 10 ms units clocked by a tick divider that restarts on load.
`timescale 1ns/1ps
`default_nettype none
`include "bss_defs.svh"

module bss_unit_timer #(
    parameter int TICK_CYCLES = `BSS_TICK_MS * `BSS_CLK_KHZ,
    parameter int UNIT_W = 7
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Load request and count.
    input wire logic load,
    input wire logic [UNIT_W-1:0] loadUnits,
    // Expiry level.
    output logic done
);
    import bss_pkg::*;

    localparam int PRE_W = $clog2(TICK_CYCLES);
    localparam logic [PRE_W-1:0] PRE_TOP = PRE_W'(TICK_CYCLES - 1);

    logic [PRE_W-1:0] preCount;
    logic [UNIT_W-1:0] units;

    wire tick = (preCount == '0);

    assign done = (units == '0);

    // The divider restarts on load so the first unit is a full 10 ms.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            preCount <= PRE_TOP;
            units <= '0;
        end else if (load) begin
            preCount <= PRE_TOP;
            units <= loadUnits;
        end else begin
            preCount <= tick ? PRE_TOP : preCount - 1'b1;
            if (tick && !done) begin
                units <= units - 1'b1;
            end
        end
    end

endmodule : bss_unit_timer
`default_nettype wire

// [hw/bss_sequencer.sv]
// Brake and stop sequencer with its APB register file.
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "bss_defs.svh"

module bss_sequencer #(
    parameter int TICK_CYCLES = `BSS_TICK_MS * `BSS_CLK_KHZ,
    parameter int SYNC_W = 4
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Register bus.
    input wire bss_pkg::bss_apb_req_t apbReq,
    output bss_pkg::bss_apb_rsp_t apbRsp,
    // Command and alarm pins.
    input wire logic servo_off_cmd,
    input wire logic alarmIn,
    input wire logic alarmZeroSpeedOk,
    input wire logic overtravelIn,
    // Speed magnitude from the speed loop.
    input wire bss_pkg::bss_speed_t motorSpeed,
    // Brake and power stage.
    output logic brake_release_out,
    output bss_pkg::bss_drive_t drive
);
    import bss_pkg::*;

    function automatic bss_speed_t clampRange(
        input logic [31:0] v,
        input bss_speed_t lo,
        input bss_speed_t hi
    );
        if (v < {18'h00000, lo}) begin
            return lo;
        end else if (v > {18'h00000, hi}) begin
            return hi;
        end
        return v[13:0];
    endfunction : clampRange

    function automatic bss_drive_t driveOf(
        input bss_state_t s,
        input logic [1:0] method,
        input logic decelSel
    );
        bss_drive_t d;
        d = '0;
        case (s)
            S_RUN: begin
                d.powerOn = 1'b1;
            end
            S_ZSTOP: begin
                d.powerOn = 1'b1;
                d.zeroClamp = !decelSel;
                d.decel = decelSel;
            end
            S_DELAY: begin
                d.powerOn = 1'b1;
                d.zeroClamp = 1'b1;
            end
            S_RSTOP: begin
                d.dynBrake = (method != 2'h2);
                d.coast = (method == 2'h2);
            end
            default: begin
                d.dynBrake = (method == 2'h0);
                d.coast = (method != 2'h0);
            end
        endcase
        return d;
    endfunction : driveOf

    // Pin synchroniser: servo off, alarm, zero-speed class, overtravel.
    logic [SYNC_W-1:0] syncA;
    logic [SYNC_W-1:0] syncB;
    wire [SYNC_W-1:0] pinRaw = {overtravelIn, alarmZeroSpeedOk, alarmIn, servo_off_cmd};

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA <= SYNC_W'(`BSS_RST_SYNC);
            syncB <= SYNC_W'(`BSS_RST_SYNC);
        end else begin
            syncA <= pinRaw;
            syncB <= syncA;
        end
    end

    wire offS = syncB[0];
    wire alarmS = syncB[1];
    wire zsOkS = syncB[2];
    wire otS = syncB[3];

    // Register file.
    logic ctlLinear;
    logic ctlZsEn;
    logic ctlDecel;
    logic [1:0] pendMethod;
    logic [1:0] activeMethod;
    bss_units_t delayUnits;
    bss_units_t waitUnits;
    bss_speed_t rotLevel;
    bss_speed_t linLevel;
    bss_speed_t maxSpeed;
    logic [31:0] readData;
    bss_state_t state;
    bss_state_t next_state;

    wire [7:0] regAddr = apbReq.paddr;
    wire setupPh = apbReq.psel & ~apbReq.penable;
    wire accessPh = apbReq.psel & apbReq.penable;
    wire hitCtl = (regAddr == `BSS_ADDR_CONTROL);
    wire hitDly = (regAddr == `BSS_ADDR_DELAY);
    wire hitRot = (regAddr == `BSS_ADDR_ROT_LEVEL);
    wire hitLin = (regAddr == `BSS_ADDR_LIN_LEVEL);
    wire hitWait = (regAddr == `BSS_ADDR_WAIT);
    wire hitMax = (regAddr == `BSS_ADDR_MAX_SPEED);
    wire hitStat = (regAddr == `BSS_ADDR_STATUS);
    wire mapped = hitCtl | hitDly | hitRot | hitLin | hitWait | hitMax | hitStat;
    wire wrEn = accessPh & apbReq.pwrite & mapped;
    wire [31:0] wd = apbReq.pwdata;

    wire bss_speed_t wrDelay = clampRange(wd, `BSS_DELAY_MIN, `BSS_DELAY_MAX);
    wire bss_speed_t wrWait = clampRange(wd, `BSS_WAIT_MIN, `BSS_WAIT_MAX);
    wire bss_speed_t wrLevel = clampRange(wd, `BSS_LEVEL_MIN, `BSS_LEVEL_MAX);
    wire [1:0] wdMethod = wd[`BSS_CTL_METHOD_HI:`BSS_CTL_METHOD_LO];
    wire [1:0] wrMethod = (wdMethod > `BSS_METHOD_MAX) ? `BSS_METHOD_MAX : wdMethod;

    wire [31:0] ctlWord = {26'h0000000, pendMethod, 1'b0, ctlDecel, ctlZsEn, ctlLinear};
    wire [31:0] statWord = {22'h000000, offS, alarmS, otS, activeMethod,
                            drive.powerOn, brake_release_out, state};
    wire [31:0] next_readData = hitCtl ? ctlWord :
                                hitDly ? {25'h0000000, delayUnits} :
                                hitRot ? {18'h00000, rotLevel} :
                                hitLin ? {18'h00000, linLevel} :
                                hitWait ? {25'h0000000, waitUnits} :
                                hitMax ? {18'h00000, maxSpeed} :
                                hitStat ? statWord : 32'h00000000;

    assign apbRsp.prdata = readData;
    assign apbRsp.pready = 1'b1;
    assign apbRsp.pslverr = accessPh & ~mapped;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            readData <= 32'h00000000;
        end else if (setupPh) begin
            readData <= next_readData;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctlLinear <= `BSS_RST_LINEAR;
            ctlZsEn <= `BSS_RST_ZS_EN;
            ctlDecel <= `BSS_RST_DECEL;
            pendMethod <= `BSS_RST_METHOD;
            delayUnits <= `BSS_RST_DELAY;
            rotLevel <= `BSS_RST_ROT_LEVEL;
            linLevel <= `BSS_RST_LIN_LEVEL;
            waitUnits <= `BSS_RST_WAIT;
            maxSpeed <= `BSS_RST_MAX_SPEED;
        end else if (wrEn) begin
            if (hitCtl) begin
                ctlLinear <= wd[`BSS_CTL_LINEAR];
                ctlZsEn <= wd[`BSS_CTL_ZS_EN];
                ctlDecel <= wd[`BSS_CTL_DECEL];
                pendMethod <= wrMethod;
            end else if (hitDly) begin
                delayUnits <= wrDelay[6:0];
            end else if (hitRot) begin
                rotLevel <= wrLevel;
            end else if (hitLin) begin
                linLevel <= wrLevel;
            end else if (hitWait) begin
                waitUnits <= wrWait[6:0];
            end else if (hitMax) begin
                maxSpeed <= wrLevel;
            end
        end
    end

    // The stop method in use only changes when the servo is switched back on.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            activeMethod <= `BSS_RST_METHOD;
        end else if (state == S_STOPPED && next_state == S_RUN) begin
            activeMethod <= pendMethod;
        end
    end

    // Speed levels and rest detection.
    wire bss_speed_t progThr = ctlLinear ? linLevel : rotLevel;
    wire bss_speed_t effThr = (progThr > maxSpeed) ? maxSpeed : progThr;
    wire belowThr = (motorSpeed < effThr);
    wire atRest = (motorSpeed == 14'h0000);
    wire zsAllowed = ctlZsEn & zsOkS;
    wire hardAlarm = alarmS & ~zsAllowed;
    logic timerDone;

    // Sequencer state machine.
    always_comb begin
        next_state = state;
        case (state)
            S_RUN: begin
                if (alarmS) begin
                    if (zsAllowed) begin
                        next_state = atRest ? S_DELAY : S_ZSTOP;
                    end else begin
                        next_state = atRest ? S_STOPPED : S_RSTOP;
                    end
                end else if (offS) begin
                    next_state = atRest ? S_DELAY : S_RSTOP;
                end
            end
            S_ZSTOP: begin
                if (atRest) begin
                    next_state = S_DELAY;
                end
            end
            S_DELAY: begin
                if (hardAlarm || timerDone) begin
                    next_state = S_STOPPED;
                end
            end
            S_RSTOP: begin
                if (belowThr || timerDone) begin
                    next_state = S_STOPPED;
                end
            end
            default: begin
                if (!offS && !alarmS) begin
                    next_state = S_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_STOPPED;
        end else begin
            state <= next_state;
        end
    end

    // One timer serves the power-off delay and the brake wait in turn.
    wire enterDelay = (next_state == S_DELAY) && (state != S_DELAY);
    wire enterRstop = (next_state == S_RSTOP) && (state != S_RSTOP);
    wire timerLoad = enterDelay | enterRstop;
    wire bss_units_t timerUnits = enterDelay ? delayUnits : waitUnits;

    bss_unit_timer #(
        .TICK_CYCLES(TICK_CYCLES),
        .UNIT_W(7)
    ) u_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .load(timerLoad),
        .loadUnits(timerUnits),
        .done(timerDone)
    );

    // Brake release holds in run, zero-speed stop and running stop; overtravel is not a cause.
    wire next_brake = (next_state == S_RUN) || (next_state == S_ZSTOP) ||
                      (next_state == S_RSTOP);
    wire bss_drive_t next_drive = driveOf(next_state, activeMethod, ctlDecel);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            brake_release_out <= 1'b0;
            drive <= '0;
        end else begin
            brake_release_out <= next_brake;
            drive <= next_drive;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    a_rest_brake_drop: assert property (
        (state == S_RUN && offS && !alarmS && atRest) |=> !brake_release_out && drive.powerOn
    ) else $error("Brake release not dropped at once on servo off at rest.");

    a_delay_power_hold: assert property (
        (state == S_DELAY && !timerDone && !hardAlarm) |=> drive.powerOn && !brake_release_out
    ) else $error("Power removed before the servo off delay ran out.");

    a_zero_delay_off: assert property (
        (state == S_RUN && offS && !alarmS && atRest && delayUnits == 7'h00)
        |=> ##[1:2] !drive.powerOn
    ) else $error("Zero servo off delay did not remove power promptly.");

    a_alarm_power_cut: assert property (
        (state == S_RUN && hardAlarm) |=> !drive.powerOn
    ) else $error("Alarm did not cut motor power at once.");

    a_alarm_in_delay: assert property (
        (state == S_DELAY && hardAlarm) |=> state == S_STOPPED && !drive.powerOn
    ) else $error("Alarm did not override the servo off delay.");

    a_level_brake: assert property (
        (state == S_RSTOP && (belowThr || timerDone)) |=> !brake_release_out
    ) else $error("Running stop kept the brake released past its condition.");

    a_zs_hold: assert property (
        (state == S_ZSTOP && !atRest) |=> drive.powerOn && brake_release_out
    ) else $error("Zero-speed stop lost power or brake release before rest.");

    a_thr_clamp: assert property (
        (effThr <= maxSpeed) && (effThr <= progThr)
    ) else $error("Effective speed level above the motor maximum.");

    a_method_stable: assert property (
        (state != S_STOPPED) |=> $stable(activeMethod)
    ) else $error("Stop method changed without a restart.");

    a_run_keeps_brake: assert property (
        (state == S_RUN && !offS && !alarmS) |=> brake_release_out
    ) else $error("Brake applied while the servo stays on.");

    c_rest_off: cover property (
        (state == S_DELAY) ##1 (state == S_STOPPED)
    );
    c_run_stop: cover property (
        (state == S_RSTOP && timerDone)
    );
    c_zs_stop: cover property (
        (state == S_ZSTOP) ##1 (state == S_DELAY)
    );
    c_restart: cover property (
        (state == S_STOPPED) ##1 (state == S_RUN)
    );

endmodule : bss_sequencer
`default_nettype wire

// [verification/bss_motor_model.sv]
// Motor model that turns the power stage state into a measured speed.
`timescale 1ns/1ps
`default_nettype none

module bss_motor_model (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Power stage and host speed reference.
    input wire bss_pkg::bss_drive_t drive,
    input wire bss_pkg::bss_speed_t target,
    input wire bss_pkg::bss_speed_t decay,
    // Measured speed magnitude.
    output bss_pkg::bss_speed_t motorSpeed
);
    import bss_pkg::*;
    wire logic driven;
    bss_speed_t next_motorSpeed;
    // A load that never slows down is modelled by a decay of zero.
    assign driven = drive.powerOn && !drive.zeroClamp && !drive.decel;
    assign next_motorSpeed = driven ? target : (motorSpeed > decay ? motorSpeed - decay : '0);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            motorSpeed <= '0;
        end else begin
            motorSpeed <= next_motorSpeed;
        end
    end
endmodule : bss_motor_model

`default_nettype wire

// [verification/testbench.sv]
// Self-checking testbench of the brake and stop sequencer.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import bss_pkg::*;
    localparam int T = 4;
    localparam logic [39:0] RST_TAB [8] = '{40'h00_00000002, 40'h04_00000000,
        40'h08_00000064, 40'h0C_0000000A, 40'h10_00000032, 40'h14_00002710,
        40'h18_00000204, 40'h1C_00000000};
    localparam logic [71:0] CLAMP_TAB [5] = '{72'h04_00000063_00000032,
        72'h10_00000003_0000000A, 72'h08_00004E20_00002710,
        72'h00_00000032_00000022, 72'h18_FFFFFFFF_00000204};
    localparam logic [63:0] THR_TAB [3] = '{64'h02_08_0064_2710_0064,
        64'h02_08_03E8_00C8_00C8, 64'h03_0C_0032_2710_0032};
    logic core_clk;
    logic rst_n;
    bss_apb_req_t req;
    bss_apb_rsp_t rsp;
    logic servoOff;
    logic alarm;
    logic zsOk;
    logic overtravel;
    bss_speed_t speed;
    bss_speed_t target;
    bss_speed_t decay;
    logic brake;
    bss_drive_t drv;
    logic [31:0] rdData;
    logic slvErr;
    int mismatches;
    int checked;
    int n;

    bss_sequencer #(.TICK_CYCLES(T)) dut (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .apbReq(req),
        .apbRsp(rsp),
        .servo_off_cmd(servoOff),
        .alarmIn(alarm),
        .alarmZeroSpeedOk(zsOk),
        .overtravelIn(overtravel),
        .motorSpeed(speed),
        .brake_release_out(brake),
        .drive(drv)
    );

    bss_motor_model motor (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .drive(drv),
        .target(target),
        .decay(decay),
        .motorSpeed(speed)
    );

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic test_done();
        if (mismatches == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge core_clk);
        req.penable <= 1'b1;
        @(posedge core_clk);
        while (rsp.pready !== 1'b1) begin
            @(posedge core_clk);
        end
        rdData = rsp.prdata;
        slvErr = rsp.pslverr;
        req <= '0;
    endtask : apb

    task automatic pins(input logic off, input logic al);
        @(posedge core_clk);
        servoOff <= off;
        alarm <= al;
    endtask : pins

    // Counts falling edges until the brake or power output reaches a level.
    task automatic waitFor(input logic pwr, input logic v, output int cnt);
        cnt = 0;
        while (((pwr ? drv.powerOn : brake) !== v) && cnt < 3000) begin
            @(negedge core_clk);
            cnt++;
        end
    endtask : waitFor

    task automatic run();
        pins(1'b0, 1'b0);
        waitFor(1'b1, 1'b1, n);
        repeat (2) @(negedge core_clk);
    endtask : run

    initial begin
        #(40 * 30000);
        mismatches++;
        test_done();
    end

    initial begin
        req = '0;
        servoOff = 1'b1;
        alarm = 1'b0;
        zsOk = 1'b0;
        overtravel = 1'b0;
        target = '0;
        decay = '0;
        mismatches = 0;
        checked = 0;
        rst_n = 1'b0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        foreach (RST_TAB[i]) begin
            apb(1'b0, RST_TAB[i][39:32], 32'h0);
            chk("reset value", RST_TAB[i][31:0], rdData);
        end
        chk("unmapped error", 32'h1, {31'h0, slvErr});
        foreach (CLAMP_TAB[i]) begin
            apb(1'b1, CLAMP_TAB[i][71:64], CLAMP_TAB[i][63:32]);
            apb(1'b0, CLAMP_TAB[i][71:64], 32'h0);
            chk("clamped value", CLAMP_TAB[i][31:0], rdData);
        end
        apb(1'b1, 8'h00, 32'h2);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, 8'h04, 32'(k * 3));
            run();
            pins(1'b1, 1'b0);
            waitFor(1'b0, 1'b0, n);
            chk("brake drop latency", 32'h1, {31'h0, n <= 5});
            chk("power at brake drop", 32'h1, {31'h0, drv.powerOn});
            waitFor(1'b1, 1'b0, n);
            chk("power-off delay", 32'h1, {31'h0, n >= k*3*T - T + 1 && n <= k*3*T + 3});
            chk("stopped dynamic brake", 32'h1, {31'h0, drv.dynBrake});
        end
        apb(1'b1, 8'h04, 32'h32);
        for (int k = 0; k < 2; k++) begin
            run();
            if (k == 1) begin
                pins(1'b1, 1'b0);
                waitFor(1'b0, 1'b0, n);
            end
            pins(servoOff, 1'b1);
            waitFor(1'b1, 1'b0, n);
            chk("alarm power cut", 32'h1, {31'h0, n <= 5});
            chk("alarm brake", 32'h0, {31'h0, brake});
        end
        apb(1'b1, 8'h10, 32'h64);
        target <= 14'h012C;
        decay <= 14'h0001;
        foreach (THR_TAB[i]) begin
            apb(1'b1, 8'h00, 32'(THR_TAB[i][63:56]));
            apb(1'b1, THR_TAB[i][55:48], 32'(THR_TAB[i][47:32]));
            apb(1'b1, 8'h14, 32'(THR_TAB[i][31:16]));
            run();
            pins(1'b0, 1'b1);
            waitFor(1'b1, 1'b0, n);
            chk("brake held while moving", 32'h1, {31'h0, brake});
            waitFor(1'b0, 1'b0, n);
            chk("brake speed", 32'h1, {31'h0, speed < THR_TAB[i][13:0] && speed + 6 >= THR_TAB[i][13:0]});
        end
        apb(1'b1, 8'h00, 32'h3);
        apb(1'b1, 8'h14, 32'h2710);
        apb(1'b1, 8'h10, 32'hA);
        decay <= '0;
        run();
        pins(1'b0, 1'b1);
        waitFor(1'b1, 1'b0, n);
        waitFor(1'b0, 1'b0, n);
        chk("wait expiry", 32'h1, {31'h0, n >= 9*T + 1 && n <= 10*T + 3});
        for (int m = 0; m < 3; m++) begin
            apb(1'b1, 8'h00, 32'(2 + (m << 4)));
            apb(1'b0, 8'h18, 32'h0);
            chk("method before restart", 32'(m == 0 ? 0 : m - 1), 32'(rdData[6:5]));
            run();
            apb(1'b0, 8'h18, 32'h0);
            chk("method after restart", 32'(m), 32'(rdData[6:5]));
            pins(1'b1, 1'b0);
            waitFor(1'b1, 1'b0, n);
            chk("stopping brake", 32'(m != 2), {31'h0, drv.dynBrake});
            chk("stopping coast", 32'(m == 2), {31'h0, drv.coast});
            waitFor(1'b0, 1'b0, n);
            chk("stopped brake", 32'(m == 0), {31'h0, drv.dynBrake});
            chk("stopped coast", 32'(m != 0), {31'h0, drv.coast});
        end
        decay <= 14'h0002;
        apb(1'b1, 8'h04, 32'h3);
        @(posedge core_clk);
        zsOk <= 1'b1;
        for (int d = 0; d < 2; d++) begin
            apb(1'b1, 8'h00, 32'(2 + (d << 2)));
            run();
            pins(1'b0, 1'b1);
            repeat (8) @(negedge core_clk);
            chk("zero-speed stop held", 32'h1, {31'h0, drv.powerOn & brake});
            chk("zero clamp", 32'(d == 0), {31'h0, drv.zeroClamp});
            chk("decelerate", 32'(d == 1), {31'h0, drv.decel});
            waitFor(1'b0, 1'b0, n);
            chk("rest at brake drop", 32'h1, {31'h0, speed === '0 && drv.powerOn});
            waitFor(1'b1, 1'b0, n);
            chk("delay after rest", 32'h1, {31'h0, n >= 2*T + 1 && n <= 3*T + 3});
        end
        run();
        @(posedge core_clk);
        overtravel <= 1'b1;
        repeat (10) @(negedge core_clk);
        chk("overtravel brake", 32'h1, {31'h0, brake});
        apb(1'b0, 8'h18, 32'h0);
        chk("overtravel status", 32'h98, rdData);
        test_done();
    end
endmodule : testbench

`default_nettype wire
